// ==== core/lmc_regs.svh ====
`ifndef LMC_REGS_SVH
`define LMC_REGS_SVH

// Register offsets
`define LMC_OFS_MATRIX_ON 8'h05
`define LMC_OFS_MEL_EN_AB 8'h08
`define LMC_OFS_MEL_EN_CD 8'h09
`define LMC_OFS_GROUP 8'h0a
`define LMC_OFS_COMP 8'h0b
`define LMC_OFS_THR 8'h0c
`define LMC_OFS_CC_FORCE 8'h0d
`define LMC_OFS_SW_FORCE 8'h0e

// Reset values
`define LMC_RST_MATRIX_ON 1'h0
`define LMC_RST_MEL_EN 8'h00
`define LMC_RST_GROUP 7'h00
`define LMC_RST_COMP 3'h3
`define LMC_RST_THR 8'h00
`define LMC_RST_CC_FORCE 5'h00
`define LMC_RST_SW_FORCE 8'h00

// Field widths and positions
`define LMC_GROUP_W 7
`define LMC_COMP_W 3
`define LMC_CC_FORCE_W 5
`define LMC_GRP_LOWER_BIT 4
`define LMC_GRP_UPPER_BIT 5
`define LMC_GROUP_ALL_BAR_BIT 6
`define LMC_SUPPLY_BIT0 4

// LED grid and bar steps
`define LMC_ROWS 4
`define LMC_COLS 4
`define LMC_STEP_ALL 1
`define LMC_STEP_EIGHT 2
`define LMC_STEP_COL 4
`define LMC_LED_D1 4'hc

// Timing
`define LMC_CLK_PERIOD_NS 100
`define LMC_COMP_STEP_NS 860
`define LMC_COMP_STEP_CYC ((`LMC_COMP_STEP_NS + `LMC_CLK_PERIOD_NS - 1) / `LMC_CLK_PERIOD_NS)

`endif

// ==== core/lmc_pkg.sv ====
`default_nettype none
package lmc_pkg;
	typedef enum logic [2:0] {
		LMC_LINE_OFF,
		LMC_LINE_CC_FORCED,
		LMC_LINE_SWITCH_OFF,
		LMC_LINE_SUPPLY_ON,
		LMC_LINE_PWM,
		LMC_LINE_FADE,
		LMC_LINE_CC
	} lmc_line_mode_e;
endpackage // lmc_pkg
`default_nettype wire

// ==== core/lmc_on_stretch.sv ====
`default_nettype none
module lmc_on_stretch #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Drive request and hold length
	input wire logic drive_in,
	input wire logic [CNT_W-1:0] hold_cycles,
	// Stretched drive
	output logic drive_out
);
	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			drive_out <= 1'b0;
		end else if (drive_in) begin
			cnt_reg <= hold_cycles;
			drive_out <= 1'b1;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
			drive_out <= 1'b1;
		end else begin
			drive_out <= 1'b0;
		end
	end
endmodule // lmc_on_stretch
`default_nettype wire

// ==== core/lmc_line_ctrl.sv ====
`default_nettype none
module lmc_line_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Line controls
	input wire logic matrix_enable,
	input wire logic cc_force,
	input wire logic mask,
	input wire logic supply_force,
	input wire logic pwm_req,
	input wire logic fade_req,
	// Resolved mode
	output var lmc_pkg::lmc_line_mode_e mode
);
	import lmc_pkg::*;

	lmc_line_mode_e mode_next;

	always_comb begin
		if (!matrix_enable)
			mode_next = LMC_LINE_OFF;
		else if (cc_force)
			mode_next = LMC_LINE_CC_FORCED;
		else if (mask)
			mode_next = LMC_LINE_SWITCH_OFF;
		else if (supply_force)
			mode_next = LMC_LINE_SUPPLY_ON;
		else if (pwm_req)
			mode_next = LMC_LINE_PWM;
		else if (fade_req)
			mode_next = LMC_LINE_FADE;
		else
			mode_next = LMC_LINE_CC;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			mode <= LMC_LINE_OFF;
		else
			mode <= mode_next;
	end
endmodule // lmc_line_ctrl
`default_nettype wire

// ==== core/lmc_mode_config.sv ====
`include "lmc_regs.svh"
`default_nettype none
module lmc_mode_config #(
	parameter int LED_NUM = 16,
	parameter int LINE_NUM = 5,
	parameter int LEVEL_W = 5,
	parameter int HOLD_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Melody front end pins
	input wire logic melody_pin,
	input wire logic [LEVEL_W-1:0] melody_level_pin,
	// Per-line requests from the PWM and fade engine
	input wire logic [LINE_NUM-1:0] pwm_line_req,
	input wire logic [LINE_NUM-1:0] fade_line_req,
	// Matrix line modes
	output var lmc_pkg::lmc_line_mode_e matrix_line_1_mode,
	output var lmc_pkg::lmc_line_mode_e matrix_line_2_mode,
	output var lmc_pkg::lmc_line_mode_e matrix_line_3_mode,
	output var lmc_pkg::lmc_line_mode_e matrix_line_4_mode,
	output var lmc_pkg::lmc_line_mode_e matrix_line_5_mode,
	output logic [4*LINE_NUM-1:0] line_cc_led,
	// Melody drive per LED
	output logic [LED_NUM-1:0] led_melody_ctl,
	output logic [LED_NUM-1:0] led_melody_on,
	// Threshold selection
	output logic thr_auto,
	output logic [2:0] thr_fixed_idx
);
	import lmc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic matrix_enable_reg;
	logic [7:0] mel_en_ab_reg;
	logic [7:0] mel_en_cd_reg;
	logic [`LMC_GROUP_W-1:0] group_reg;
	logic [`LMC_COMP_W-1:0] comp_reg;
	logic [7:0] thr_reg;
	logic [`LMC_CC_FORCE_W-1:0] cc_force_reg;
	logic [7:0] sw_force_reg;

	// Address decode shared by the write and read paths
	wire sel_matrix = (reg_addr == `LMC_OFS_MATRIX_ON);
	wire sel_mel_ab = (reg_addr == `LMC_OFS_MEL_EN_AB);
	wire sel_mel_cd = (reg_addr == `LMC_OFS_MEL_EN_CD);
	wire sel_group = (reg_addr == `LMC_OFS_GROUP);
	wire sel_comp = (reg_addr == `LMC_OFS_COMP);
	wire sel_thr = (reg_addr == `LMC_OFS_THR);
	wire sel_cc = (reg_addr == `LMC_OFS_CC_FORCE);
	wire sel_sw = (reg_addr == `LMC_OFS_SW_FORCE);

	// Writes to unmapped offsets match no select and are lost
	wire wr_matrix = reg_wr && sel_matrix;
	wire wr_mel_ab = reg_wr && sel_mel_ab;
	wire wr_mel_cd = reg_wr && sel_mel_cd;
	wire wr_group = reg_wr && sel_group;
	wire wr_comp = reg_wr && sel_comp;
	wire wr_thr = reg_wr && sel_thr;
	wire wr_cc = reg_wr && sel_cc;
	wire wr_sw = reg_wr && sel_sw;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			matrix_enable_reg <= `LMC_RST_MATRIX_ON;
			mel_en_ab_reg <= `LMC_RST_MEL_EN;
			mel_en_cd_reg <= `LMC_RST_MEL_EN;
			group_reg <= `LMC_RST_GROUP;
			comp_reg <= `LMC_RST_COMP;
			thr_reg <= `LMC_RST_THR;
			cc_force_reg <= `LMC_RST_CC_FORCE;
			sw_force_reg <= `LMC_RST_SW_FORCE;
		end else begin
			if (wr_matrix)
				matrix_enable_reg <= reg_wdata[0];
			if (wr_mel_ab)
				mel_en_ab_reg <= reg_wdata;
			if (wr_mel_cd)
				mel_en_cd_reg <= reg_wdata;
			if (wr_group)
				group_reg <= reg_wdata[`LMC_GROUP_W-1:0];
			if (wr_comp)
				comp_reg <= reg_wdata[`LMC_COMP_W-1:0];
			if (wr_thr)
				thr_reg <= reg_wdata;
			if (wr_cc)
				cc_force_reg <= reg_wdata[`LMC_CC_FORCE_W-1:0];
			if (wr_sw)
				sw_force_reg <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Narrow fields are zero-extended to the bus width
	wire [7:0] rd_matrix = {7'h00, matrix_enable_reg};
	wire [7:0] rd_group = {1'h0, group_reg};
	wire [7:0] rd_comp = {5'h00, comp_reg};
	wire [7:0] rd_cc = {3'h0, cc_force_reg};

	wire [7:0] rd_mux =
		sel_matrix ? rd_matrix :
		sel_mel_ab ? mel_en_ab_reg :
		sel_mel_cd ? mel_en_cd_reg :
		sel_group ? rd_group :
		sel_comp ? rd_comp :
		sel_thr ? thr_reg :
		sel_cc ? rd_cc :
		sel_sw ? sw_force_reg :
		8'h00;

	// Read data stands for the one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Melody input synchronisers

	logic mel_meta_reg;
	logic mel_sync_reg;
	logic [LEVEL_W-1:0] lvl_meta_reg;
	logic [LEVEL_W-1:0] lvl_sync_reg;
	logic [LEVEL_W-1:0] lvl_prev_reg;
	logic [LEVEL_W-1:0] lvl_held_reg;

	// Bits of the level word can cross a cycle apart, so a new level is
	// only taken once two synchronised samples in a row agree
	wire lvl_steady = (lvl_sync_reg == lvl_prev_reg);
	wire [LEVEL_W-1:0] lvl_held_next = lvl_steady ? lvl_sync_reg : lvl_held_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mel_meta_reg <= 1'b0;
			mel_sync_reg <= 1'b0;
			lvl_meta_reg <= '0;
			lvl_sync_reg <= '0;
			lvl_prev_reg <= '0;
			lvl_held_reg <= '0;
		end else begin
			mel_meta_reg <= melody_pin;
			mel_sync_reg <= mel_meta_reg;
			lvl_meta_reg <= melody_level_pin;
			lvl_sync_reg <= lvl_meta_reg;
			lvl_prev_reg <= lvl_sync_reg;
			lvl_held_reg <= lvl_held_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Melody resolution per LED, index = row * 4 + column, row A first

	wire [LED_NUM-1:0] mel_en = {mel_en_cd_reg, mel_en_ab_reg};
	wire group_all_bar = group_reg[`LMC_GROUP_ALL_BAR_BIT];
	wire grp_upper = group_reg[`LMC_GRP_UPPER_BIT];
	wire grp_lower = group_reg[`LMC_GRP_LOWER_BIT];
	wire [HOLD_W-1:0] hold_cycles = HOLD_W'(int'(comp_reg) * `LMC_COMP_STEP_CYC);

	logic [LED_NUM-1:0] ctl_next;
	logic [LED_NUM-1:0] drive_next;
	logic [LED_NUM-1:0] drive_reg;

	genvar gr, gc;
	generate
		for (gr = 0; gr < `LMC_ROWS; gr++) begin : g_row
			for (gc = 0; gc < `LMC_COLS; gc++) begin : g_col
				localparam int IDX = gr * `LMC_COLS + gc;
				localparam int POS_COL = `LMC_ROWS - 1 - gr;
				localparam int POS_ALL = gc * `LMC_ROWS + POS_COL;
				localparam int POS_EIGHT = (gc % 2) * `LMC_ROWS + POS_COL;
				wire lit_all = lvl_held_reg > LEVEL_W'(POS_ALL * `LMC_STEP_ALL);
				wire in_eight = (gc >= 2) ? grp_upper : grp_lower;
				wire lit_eight = lvl_held_reg > LEVEL_W'(POS_EIGHT * `LMC_STEP_EIGHT);
				wire in_col = group_reg[gc];
				wire lit_col = lvl_held_reg > LEVEL_W'(POS_COL * `LMC_STEP_COL);
				assign drive_next[IDX] = group_all_bar ? lit_all :
					in_eight ? lit_eight :
					in_col ? lit_col :
					mel_en[IDX] ? mel_sync_reg : 1'b0;
				assign ctl_next[IDX] = group_all_bar | in_eight | in_col | mel_en[IDX];

				// Each LED keeps its own counter, so lamps release independently
				// turn-on compensation
				lmc_on_stretch #(
					.CNT_W(HOLD_W)
				) u_stretch (
					.clk(clk),
					.sys_rst(sys_rst),
					.drive_in(drive_reg[IDX]),
					.hold_cycles(hold_cycles),
					.drive_out(led_melody_on[IDX])
				);
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			drive_reg <= '0;
			led_melody_ctl <= '0;
		end else begin
			drive_reg <= drive_next;
			led_melody_ctl <= ctl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Threshold selection

	logic [2:0] thr_idx_next;

	always_comb begin
		thr_idx_next = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (thr_reg[i])
				thr_idx_next = 3'(i);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			thr_auto <= 1'b1;
			thr_fixed_idx <= 3'h0;
		end else begin
			thr_auto <= (thr_reg == 8'h00);
			thr_fixed_idx <= thr_idx_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Matrix line control

	lmc_line_mode_e line_mode [LINE_NUM];
	logic [4*LINE_NUM-1:0] cc_led_next;

	genvar gl;
	generate
		for (gl = 0; gl < LINE_NUM; gl++) begin : g_line
			// Line 5 has no supply switch, so its mask and supply force stay off
			localparam bit HAS_SW = (gl < `LMC_COLS);
			wire mask_bit = HAS_SW ? sw_force_reg[gl % `LMC_COLS] : 1'b0;
			wire supply_bit = HAS_SW ? sw_force_reg[`LMC_SUPPLY_BIT0 + (gl % `LMC_COLS)] : 1'b0;

			assign cc_led_next[4*gl +: 4] = HAS_SW ? 4'(gl) : `LMC_LED_D1;

			lmc_line_ctrl u_line (
				.clk(clk),
				.sys_rst(sys_rst),
				.matrix_enable(matrix_enable_reg),
				.cc_force(cc_force_reg[gl]),
				.mask(mask_bit),
				.supply_force(supply_bit),
				.pwm_req(pwm_line_req[gl]),
				.fade_req(fade_line_req[gl]),
				.mode(line_mode[gl])
			);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst)
			line_cc_led <= '0;
		else
			line_cc_led <= cc_led_next;
	end

	// Per-line mode outputs, line 1 first
	assign matrix_line_1_mode = line_mode[0];
	assign matrix_line_2_mode = line_mode[1];
	assign matrix_line_3_mode = line_mode[2];
	assign matrix_line_4_mode = line_mode[3];
	assign matrix_line_5_mode = line_mode[4];
endmodule // lmc_mode_config
`default_nettype wire

// ==== tb/lmc_mode_config_sva.sv ====
`default_nettype none
module lmc_mode_config_sva import lmc_pkg::*; #(
	parameter int LINE_NUM = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Line side
	input wire logic [LINE_NUM-1:0] pwm_line_req,
	input wire logic [LINE_NUM-1:0] fade_line_req,
	input wire lmc_pkg::lmc_line_mode_e matrix_line_1_mode,
	input wire logic [4*LINE_NUM-1:0] line_cc_led,
	input wire logic thr_auto,
	input wire logic [2:0] thr_fixed_idx
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence thr_wr;
		reg_wr && reg_addr == 8'h0c;
	endsequence
	sequence rd_at(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence
	chk_unmapped_zero: assert property (rd_at(8'hff) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_comp_unused: assert property (rd_at(8'h0b) |=> reg_rdata[7:3] == 5'h00)
		else $error("compensation spare bits set");
	chk_cc_unused: assert property (rd_at(8'h0d) |=> reg_rdata[7:5] == 3'h0)
		else $error("force spare bits set");
	chk_grp_unused: assert property (rd_at(8'h0a) |=> !reg_rdata[7])
		else $error("group spare bit set");
	chk_thr_auto: assert property (thr_wr ##2 1 |-> thr_auto == ($past(reg_wdata, 2) == 8'h00))
		else $error("auto threshold wrong");
	chk_thr_index: assert property (thr_wr ##0 $onehot(reg_wdata) ##2 1 |->
		thr_fixed_idx == 3'($clog2($past(reg_wdata, 2)))) else $error("threshold index wrong");
	chk_cc_source: assert property (!$past(sys_rst) |-> line_cc_led == 20'hc3210)
		else $error("current source led wrong");
	chk_pwm_mode: assert property (matrix_line_1_mode == LMC_LINE_PWM |-> $past(pwm_line_req[0]))
		else $error("pwm mode without request");
	chk_fade_mode: assert property (matrix_line_1_mode == LMC_LINE_FADE |->
		$past(fade_line_req[0] && !pwm_line_req[0])) else $error("fade mode wrong");
endmodule // lmc_mode_config_sva
bind lmc_mode_config lmc_mode_config_sva #(.LINE_NUM(LINE_NUM)) u_sva (.clk, .sys_rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_line_req, .fade_line_req,
	.matrix_line_1_mode, .line_cc_led, .thr_auto, .thr_fixed_idx);
`default_nettype wire

// ==== tb/lmc_mel_src.sv ====
`default_nettype none
module lmc_mel_src (
	// Clock
	input wire logic clk,
	// Wanted audio state
	input wire logic pin_req,
	input wire logic [4:0] lvl_req,
	// Pins into the block
	output logic melody_pin,
	output logic [4:0] melody_level_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		melody_pin = 1'b0;
		melody_level_pin = 5'h00;
	end
	// Audio is not tied to clk: change 37 ns after an edge
	always @(posedge clk) begin
		melody_pin <= #37 pin_req;
		melody_level_pin <= #37 lvl_req;
	end
endmodule // lmc_mel_src
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import lmc_pkg::*;
	logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, pin_req = 0, melody_pin, rd_d = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
	logic [4:0] pwm_line_req = 0, fade_line_req = 0, lvl_req = 0, melody_level_pin, l;
	lmc_line_mode_e m1, m2, m3, m4, m5;
	logic [19:0] line_cc_led;
	logic [15:0] led_melody_ctl, led_melody_on;
	logic thr_auto;
	logic [2:0] thr_fixed_idx;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h03c9b453;
	int n_mismatch = 0, compares = 0, cyc = 0, t, t0;
	localparam logic [7:0] RST_V[5] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] MASK_V[5] = '{8'h7f, 8'h07, 8'hff, 8'h1f, 8'hff};
	localparam logic [6:0] GRP_V[10] = '{7'h40, 7'h41, 7'h20, 7'h10, 7'h30, 7'h01, 7'h02,
		7'h04, 7'h08, 7'h0f};
	lmc_mode_config uut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.melody_pin, .melody_level_pin, .pwm_line_req, .fade_line_req,
		.matrix_line_1_mode(m1), .matrix_line_2_mode(m2), .matrix_line_3_mode(m3),
		.matrix_line_4_mode(m4), .matrix_line_5_mode(m5), .line_cc_led, .led_melody_ctl,
		.led_melody_on, .thr_auto, .thr_fixed_idx);
	lmc_mel_src u_src (.clk, .pin_req, .lvl_req, .melody_pin, .melody_level_pin);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Bar meter lamps for a level; level 16 gives the set of controlled lamps
	function automatic logic [15:0] bar(input logic [6:0] g, input int lv, input logic [15:0] own);
		int c, r;
		bar = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			c = i % 4;
			r = 3 - i / 4;
			if (g[6]) bar[i] = lv > c * 4 + r;
			else if (g[4] && c < 2) bar[i] = lv > 2 * (c * 4 + r);
			else if (g[5] && c > 1) bar[i] = lv > 2 * (c * 4 - 8 + r);
			else if (g[c]) bar[i] = lv > 4 * r;
			else bar[i] = own[i];
		end
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		compares++;
		if (got !== want) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d) chk(16'(reg_rdata), 16'(exp_q.pop_front()));
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		tick(2);
		sys_rst <= 1'b0;
		tick(1);
		for (int i = 0; i < 5; i++) rd(8'(10 + i), RST_V[i]);
		rd(8'hff, 8'h00);
		// One register at a time, so groups never meet a fixed threshold
		for (int i = 0; i < 5; i++) begin
			d = 8'(rnd());
			if (i == 2) d = 8'h01 << d[2:0];
			wr(8'(10 + i), d);
			rd(8'(10 + i), d & MASK_V[i]);
			wr(8'(10 + i), RST_V[i]);
		end
		$display("test registers done");
		for (int n = 0; n < 8; n++) begin
			wr(8'h0c, 8'h01 << n);
			tick(1);
			chk(16'({thr_auto, thr_fixed_idx}), 16'(n));
		end
		wr(8'h0c, 8'h14);
		tick(1);
		chk(16'(thr_fixed_idx), 16'h2);
		wr(8'h0c, 8'h00);
		tick(1);
		chk(16'(thr_auto), 16'h1);
		$display("test threshold done");
		wr(8'h05, 8'h01);
		wr(8'h0e, 8'h11);
		tick(1);
		chk(16'(m1), 16'(LMC_LINE_SWITCH_OFF));
		wr(8'h0e, 8'h10);
		tick(1);
		chk(16'(m1), 16'(LMC_LINE_SUPPLY_ON));
		wr(8'h0d, 8'h1f);
		tick(1);
		chk(16'({m5, m4, m3, m2, m1}), 16'({5{LMC_LINE_CC_FORCED}}));
		wr(8'h0d, 8'h00);
		wr(8'h0e, 8'h00);
		pwm_line_req <= 5'h1f;
		fade_line_req <= 5'h1f;
		tick(2);
		chk(16'({m5, m4, m3, m2, m1}), 16'({5{LMC_LINE_PWM}}));
		pwm_line_req <= 5'h00;
		tick(2);
		chk(16'(m1), 16'(LMC_LINE_FADE));
		fade_line_req <= 5'h00;
		tick(2);
		chk(16'(m1), 16'(LMC_LINE_CC));
		wr(8'h05, 8'h00);
		tick(1);
		chk(16'(m1), 16'(LMC_LINE_OFF));
		$display("test line modes done");
		wr(8'h08, 8'h01);
		for (int k = 0; k < 8; k += 3) begin
			wr(8'h0b, 8'(k));
			pin_req <= 1'b1;
			tick(8);
			chk(led_melody_on & led_melody_ctl, 16'h0001);
			pin_req <= 1'b0;
			t = 0;
			while (led_melody_on[0] !== 1'b0 && t < 100) begin
				tick(1);
				t++;
			end
			if (k == 0) t0 = t;
			chk(16'(t - t0), 16'(9 * k));
		end
		$display("test melody stretch done");
		wr(8'h0b, 8'h00);
		pin_req <= 1'b1;
		// Threshold stays automatic while groups are set
		// host auto threshold
		foreach (GRP_V[k]) begin
			l = 5'(rnd() % 17);
			lvl_req <= l;
			wr(8'h0a, 8'(GRP_V[k]));
			tick(8);
			chk(led_melody_ctl, bar(GRP_V[k], 16, 16'h0001));
			chk(led_melody_on, bar(GRP_V[k], int'(l), 16'h0001));
		end
		$display("test bar meters done");
		end_sim();
	end
endmodule // testbench
`default_nettype wire
